// file: design/block_seq_pkg.sv
// Purpose: Shared constants and types for the block program sequencer.
// Assumes: Function codes arrive as 10-bit binary values of the decimal code.
// Notes: Time constants are given in milliseconds and converted at the clock rate.
package block_seq_pkg;

  localparam int FUNC_W = 10;
  localparam int PRESET_W = 16;
  localparam int BLOCK_W = 8;

  // Function codes (decimal value in the trailing comment).
  localparam logic [FUNC_W-1:0] FC_PERIPH_SERVICE_DISABLE = 10'h11f; // 287
  localparam logic [FUNC_W-1:0] FC_PERIPH_SERVICE_ENABLE = 10'h120; // 288
  localparam logic [FUNC_W-1:0] FC_BLOCK_BEGIN = 10'h060; // 096
  localparam logic [FUNC_W-1:0] FC_BLOCK_END = 10'h321; // 801
  localparam logic [FUNC_W-1:0] FC_BRANCH = 10'h322; // 802
  localparam logic [FUNC_W-1:0] FC_BRANCH_ALT = 10'h323; // 803
  localparam logic [FUNC_W-1:0] FC_BRANCH_CLOSE = 10'h324; // 804
  localparam logic [FUNC_W-1:0] FC_COND_WAIT = 10'h325; // 805
  localparam logic [FUNC_W-1:0] FC_COND_EXIT = 10'h326; // 806
  localparam logic [FUNC_W-1:0] FC_BLOCK_PAUSE = 10'h32b; // 811
  localparam logic [FUNC_W-1:0] FC_BLOCK_RESTART = 10'h32c; // 812
  localparam logic [FUNC_W-1:0] FC_HUNDRED_MS_DELAY = 10'h32d; // 813
  localparam logic [FUNC_W-1:0] FC_COUNT_HOLD = 10'h32e; // 814
  localparam logic [FUNC_W-1:0] FC_TEN_MS_DELAY = 10'h32f; // 815
  localparam logic [FUNC_W-1:0] FC_HUNDRED_MS_DELAY_EXT = 10'h330; // 816
  localparam logic [FUNC_W-1:0] FC_COUNT_HOLD_EXT = 10'h332; // 818

  // Timing.
  localparam int CLK_HZ = 40_000_000;
  localparam int TEN_MS_MS = 10;
  localparam int HUNDRED_MS_MS = 100;
  localparam int TEN_MS_CYC = (CLK_HZ / 1000) * TEN_MS_MS;
  localparam int HUNDRED_MS_CYC = (CLK_HZ / 1000) * HUNDRED_MS_MS;

  // Reset values.
  localparam logic PERIPH_SERVICE_RST = 1'b1;
  localparam logic [BLOCK_W-1:0] BLOCK_RST = 8'h00;

  typedef enum logic [1:0] {
    UNIT_TEN_MS = 2'h0,
    UNIT_HUNDRED_MS = 2'h1,
    UNIT_EVENT = 2'h2
  } wait_unit_t;

  typedef enum logic [3:0] {
    S_RUN = 4'b0001,
    S_TO_ALT = 4'b0010,
    S_TO_CLOSE = 4'b0100,
    S_TO_END = 4'b1000
  } seq_state_t;

endpackage : block_seq_pkg

// file: design/wait_timer.sv
// Purpose: Down-counting wait timer in 10 ms or 100 ms units, or counting external events.
// Assumes: start is a one-cycle pulse; event_in is one cycle per counted event.
// Notes: A preset of zero completes on the cycle after start.
`timescale 1ns/1ps
module wait_timer #(
  parameter int TEN_CYC = block_seq_pkg::TEN_MS_CYC,
  parameter int HUND_CYC = block_seq_pkg::HUNDRED_MS_CYC,
  parameter int PRESET_W = block_seq_pkg::PRESET_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic start,
  input wire block_seq_pkg::wait_unit_t unit_sel,
  input wire logic [PRESET_W-1:0] preset,
  input wire logic event_in,
  output logic busy_q,
  output logic done_q
);

  block_seq_pkg::wait_unit_t unit_q;
  logic [PRESET_W-1:0] remain_q;
  logic [31:0] pre_q;
  logic [31:0] pre_lim;
  logic step;

  assign pre_lim = (unit_q == block_seq_pkg::UNIT_HUNDRED_MS) ? 32'(HUND_CYC - 1)
                                                              : 32'(TEN_CYC - 1);
  assign step = (unit_q == block_seq_pkg::UNIT_EVENT) ? event_in : (pre_q == pre_lim);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (start || !busy_q || step) begin
        pre_q <= 32'h0000_0000;
      end else begin
        pre_q <= pre_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unit_q <= block_seq_pkg::UNIT_TEN_MS;
      remain_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        unit_q <= unit_sel;
        remain_q <= preset;
        busy_q <= 1'b1;
        done_q <= 1'b0;
      end else if (busy_q) begin
        if (remain_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else if (step) begin
          remain_q <= remain_q - PRESET_W'(1);
        end
      end
    end
  end

endmodule : wait_timer

// file: design/block_program_sequencer.sv
// Purpose: Decides, instruction by instruction, whether block program instructions run,
//   are skipped or must be held, and keeps block pause and peripheral servicing state.
// Assumes: The execution unit presents one instruction per instr_valid pulse and re-presents
//   a held instruction on a later cycle without advancing its program position.
// Notes: Branches do not nest; a second branch inside a skipped group is ignored.
`timescale 1ns/1ps

// How it works
// [R1] Code 287 stops peripheral servicing when in parallel or servicing priority mode.
// [R2] Code 288 restores peripheral servicing in parallel mode after a 287 suspension.
// [R3] Code 096 opens a block region named by its block number operand.
// [R4] Code 801 closes the current block region.
// [R5] Code 811 marks the operand-named block program as paused.
// [R6] Code 812 clears the pause of the operand-named block program.
// [R7] Code 806 skips to block end and exits when condition or operand bit is ON.
// [R8] Inverted 806 skips to block end and exits when the operand bit is OFF.
// [R9] Code 802 runs following code when test is OFF, skips to 803 when ON.
// [R10] Inverted 802 runs following code when bit ON, skips to 803 when OFF.
// [R11] Code 803 starts the group run when the preceding branch skipped to it.
// [R12] Code 804 closes the branch region; execution then continues unconditionally.
// [R13] Code 805 holds the block until condition or operand bit turns ON.
// [R14] Inverted 805 holds the block until the operand bit turns OFF.
// [R15] Codes 813/816/815 hold for set_value units of 100 or 10 ms; 814/818 until count reached.
// [R16] Held or paused blocks resume at the stopped instruction, not at block start.
module block_program_sequencer #(
  parameter int TEN_CYC = block_seq_pkg::TEN_MS_CYC,
  parameter int HUND_CYC = block_seq_pkg::HUNDRED_MS_CYC,
  parameter int BLOCK_W = block_seq_pkg::BLOCK_W,
  parameter int PRESET_W = block_seq_pkg::PRESET_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [block_seq_pkg::FUNC_W-1:0] func_code,
  input wire logic invert,
  input wire logic has_operand,
  input wire logic operand_bit,
  input wire logic exec_cond,
  input wire logic [BLOCK_W-1:0] block_num,
  input wire logic [PRESET_W-1:0] set_value,
  input wire logic count_tick,
  input wire logic parallel_mode,
  input wire logic periph_priority_mode,
  output logic resp_valid_q,
  output logic resp_exec_q,
  output logic resp_hold_q,
  output logic resp_exit_q,
  output logic periph_service_on_q,
  output logic in_block_q,
  output logic [BLOCK_W-1:0] cur_block_q,
  output logic [(1<<BLOCK_W)-1:0] block_paused_q
);

  // Test value of a conditional: operand bit when given, else the execution condition.
  function automatic logic test_on(input logic has_op, input logic op, input logic ec);
    test_on = has_op ? op : ec;
  endfunction : test_on

  // True when the conditional acts: exit taken, branch skipped.
  function automatic logic cond_hit(input logic inv, input logic has_op, input logic op,
                                    input logic ec);
    cond_hit = inv ? !op : test_on(has_op, op, ec);
  endfunction : cond_hit

  function automatic logic is_wait_code(input logic [block_seq_pkg::FUNC_W-1:0] fc);
    is_wait_code = (fc == block_seq_pkg::FC_HUNDRED_MS_DELAY) ||
                   (fc == block_seq_pkg::FC_HUNDRED_MS_DELAY_EXT) ||
                   (fc == block_seq_pkg::FC_TEN_MS_DELAY) ||
                   (fc == block_seq_pkg::FC_COUNT_HOLD) ||
                   (fc == block_seq_pkg::FC_COUNT_HOLD_EXT);
  endfunction : is_wait_code

  block_seq_pkg::seq_state_t state_q;
  block_seq_pkg::seq_state_t state_d;
  block_seq_pkg::wait_unit_t unit_d;
  logic hit;
  logic blk_paused;
  logic exec_d;
  logic hold_d;
  logic exit_d;
  logic in_block_d;
  logic [BLOCK_W-1:0] cur_block_d;
  logic pause_set;
  logic pause_clr;
  logic periph_d;
  logic armed_q;
  logic armed_d;
  logic tmr_start;
  logic tmr_done;

  assign hit = instr_valid;

  // A paused block is checked by the number on its own begin, else by the open block.
  assign blk_paused = (func_code == block_seq_pkg::FC_BLOCK_BEGIN) ? block_paused_q[block_num]
                    : (in_block_q && block_paused_q[cur_block_q]);

  always_comb begin
    unit_d = block_seq_pkg::UNIT_TEN_MS;
    if ((func_code == block_seq_pkg::FC_HUNDRED_MS_DELAY) ||
        (func_code == block_seq_pkg::FC_HUNDRED_MS_DELAY_EXT)) begin
      unit_d = block_seq_pkg::UNIT_HUNDRED_MS;
    end else if ((func_code == block_seq_pkg::FC_COUNT_HOLD) ||
                 (func_code == block_seq_pkg::FC_COUNT_HOLD_EXT)) begin
      unit_d = block_seq_pkg::UNIT_EVENT;
    end
  end

  always_comb begin
    state_d = state_q;
    exec_d = 1'b0;
    hold_d = 1'b0;
    exit_d = 1'b0;
    in_block_d = in_block_q;
    cur_block_d = cur_block_q;
    pause_set = 1'b0;
    pause_clr = 1'b0;
    periph_d = periph_service_on_q;
    armed_d = armed_q;
    tmr_start = 1'b0;
    if (hit) begin
      if (blk_paused) begin
        // The caller keeps its position, so the block picks up here once restarted.
        hold_d = 1'b1; // [R16]
      end else begin
        case (state_q)
          block_seq_pkg::S_RUN: begin
            exec_d = 1'b1;
            case (func_code)
              block_seq_pkg::FC_BLOCK_BEGIN: begin
                in_block_d = 1'b1; // [R3]
                cur_block_d = block_num; // [R3]
              end
              block_seq_pkg::FC_BLOCK_END: begin
                in_block_d = 1'b0; // [R4]
              end
              block_seq_pkg::FC_BLOCK_PAUSE: begin
                pause_set = exec_cond; // [R5]
              end
              block_seq_pkg::FC_BLOCK_RESTART: begin
                pause_clr = exec_cond; // [R6]
              end
              block_seq_pkg::FC_COND_EXIT: begin
                if (cond_hit(invert, has_operand, operand_bit, exec_cond)) begin // [R7] [R8]
                  state_d = block_seq_pkg::S_TO_END;
                  exit_d = 1'b1;
                end
              end
              block_seq_pkg::FC_BRANCH: begin
                if (cond_hit(invert, has_operand, operand_bit, exec_cond)) begin // [R9] [R10]
                  state_d = block_seq_pkg::S_TO_ALT;
                end
              end
              block_seq_pkg::FC_BRANCH_ALT: begin
                // Reaching the alternate group while running means the first group ran.
                state_d = block_seq_pkg::S_TO_CLOSE; // [R11]
              end
              block_seq_pkg::FC_COND_WAIT: begin
                if (invert ? operand_bit : !test_on(has_operand, operand_bit, exec_cond)) begin
                  hold_d = 1'b1; // [R13] [R14]
                  exec_d = 1'b0;
                end
              end
              block_seq_pkg::FC_PERIPH_SERVICE_DISABLE: begin
                if (exec_cond && (parallel_mode || periph_priority_mode)) begin
                  periph_d = 1'b0; // [R1]
                end
              end
              block_seq_pkg::FC_PERIPH_SERVICE_ENABLE: begin
                if (exec_cond && parallel_mode) begin
                  periph_d = 1'b1; // [R2]
                end
              end
              default: begin
                if (is_wait_code(func_code)) begin
                  if (!armed_q) begin
                    tmr_start = 1'b1; // [R15]
                    armed_d = 1'b1;
                    hold_d = 1'b1;
                    exec_d = 1'b0;
                  end else if (tmr_done) begin
                    armed_d = 1'b0; // [R15]
                  end else begin
                    hold_d = 1'b1; // [R15] [R16]
                    exec_d = 1'b0;
                  end
                end
              end
            endcase
          end
          block_seq_pkg::S_TO_ALT: begin
            if (func_code == block_seq_pkg::FC_BRANCH_ALT) begin
              state_d = block_seq_pkg::S_RUN; // [R11]
              exec_d = 1'b1;
            end else if (func_code == block_seq_pkg::FC_BRANCH_CLOSE) begin
              state_d = block_seq_pkg::S_RUN; // [R12]
              exec_d = 1'b1;
            end else if (func_code == block_seq_pkg::FC_BLOCK_END) begin
              state_d = block_seq_pkg::S_RUN; // [R4]
              in_block_d = 1'b0;
              exec_d = 1'b1;
            end
          end
          block_seq_pkg::S_TO_CLOSE: begin
            if (func_code == block_seq_pkg::FC_BRANCH_CLOSE) begin
              state_d = block_seq_pkg::S_RUN; // [R12]
              exec_d = 1'b1;
            end else if (func_code == block_seq_pkg::FC_BLOCK_END) begin
              state_d = block_seq_pkg::S_RUN; // [R4]
              in_block_d = 1'b0;
              exec_d = 1'b1;
            end
          end
          block_seq_pkg::S_TO_END: begin
            if (func_code == block_seq_pkg::FC_BLOCK_END) begin
              state_d = block_seq_pkg::S_RUN; // [R7] [R8]
              in_block_d = 1'b0;
              exec_d = 1'b1;
            end
          end
          default: begin
            state_d = block_seq_pkg::S_RUN;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= block_seq_pkg::S_RUN;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resp_valid_q <= 1'b0;
      resp_exec_q <= 1'b0;
      resp_hold_q <= 1'b0;
      resp_exit_q <= 1'b0;
    end else if (clk_en) begin
      resp_valid_q <= hit;
      resp_exec_q <= exec_d;
      resp_hold_q <= hold_d;
      resp_exit_q <= exit_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_block_q <= 1'b0;
      cur_block_q <= BLOCK_W'(block_seq_pkg::BLOCK_RST);
    end else if (clk_en) begin
      in_block_q <= in_block_d;
      cur_block_q <= cur_block_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      block_paused_q <= '0;
    end else if (clk_en) begin
      if (pause_set) begin
        block_paused_q[block_num] <= 1'b1; // [R5]
      end else if (pause_clr) begin
        block_paused_q[block_num] <= 1'b0; // [R6]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      periph_service_on_q <= block_seq_pkg::PERIPH_SERVICE_RST;
    end else if (clk_en) begin
      periph_service_on_q <= periph_d;
    end
  end

  // Arming is kept per sequencer, so only one timed hold can be pending at a time.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (clk_en) begin
      armed_q <= armed_d;
    end
  end

  wait_timer #(
    .TEN_CYC(TEN_CYC),
    .HUND_CYC(HUND_CYC),
    .PRESET_W(PRESET_W)
  ) u_wait_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .start(tmr_start),
    .unit_sel(unit_d),
    .preset(set_value),
    .event_in(count_tick),
    .busy_q(),
    .done_q(tmr_done)
  );

endmodule : block_program_sequencer

// file: test/block_seq_chk.sv
// Purpose: Port-level assertions for the block program sequencer.
// Assumes: Answers arrive one enabled cycle after the instruction is taken.
// Notes: Attached by a bind in the testbench top file.
`timescale 1ns/1ps
module block_seq_chk #(
  parameter int BLOCK_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [block_seq_pkg::FUNC_W-1:0] func_code,
  input wire logic exec_cond,
  input wire logic [BLOCK_W-1:0] block_num,
  input wire logic parallel_mode,
  input wire logic periph_priority_mode,
  input wire logic resp_valid_q,
  input wire logic resp_exec_q,
  input wire logic resp_hold_q,
  input wire logic resp_exit_q,
  input wire logic periph_service_on_q,
  input wire logic in_block_q,
  input wire logic [BLOCK_W-1:0] cur_block_q,
  input wire logic [(1<<BLOCK_W)-1:0] block_paused_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // An instruction that was taken and then really executed.
  sequence s_run(logic [9:0] code, logic c);
    instr_valid && clk_en && c && func_code == code ##1 resp_valid_q && resp_exec_q;
  endsequence

  property p_answer; instr_valid && clk_en |=> resp_valid_q; endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after instruction");
  // Judged on enabled cycles only, so a frozen answer is not taken for a spurious one.
  property p_no_spur; clk_en && !instr_valid |=> !resp_valid_q; endproperty
  a_no_spur: assert property (p_no_spur) else $error("answer without instruction");
  property p_disable;
    s_run(block_seq_pkg::FC_PERIPH_SERVICE_DISABLE,
          exec_cond && (parallel_mode || periph_priority_mode)) |-> !periph_service_on_q;
  endproperty
  a_disable: assert property (p_disable) else $error("servicing not suspended");
  property p_enable;
    s_run(block_seq_pkg::FC_PERIPH_SERVICE_ENABLE, exec_cond && parallel_mode)
      |-> periph_service_on_q;
  endproperty
  a_enable: assert property (p_enable) else $error("servicing not resumed");
  property p_begin;
    s_run(block_seq_pkg::FC_BLOCK_BEGIN, 1'b1) |-> in_block_q && cur_block_q == $past(block_num);
  endproperty
  a_begin: assert property (p_begin) else $error("block region not opened");
  property p_end; s_run(block_seq_pkg::FC_BLOCK_END, 1'b1) |-> !in_block_q; endproperty
  a_end: assert property (p_end) else $error("block region not closed");
  property p_pause;
    s_run(block_seq_pkg::FC_BLOCK_PAUSE, exec_cond) |-> block_paused_q[$past(block_num)];
  endproperty
  a_pause: assert property (p_pause) else $error("target block not paused");
  property p_restart;
    s_run(block_seq_pkg::FC_BLOCK_RESTART, exec_cond) |-> !block_paused_q[$past(block_num)];
  endproperty
  a_restart: assert property (p_restart) else $error("target block still paused");
  property p_exit;
    resp_exit_q |-> resp_valid_q && resp_exec_q && $past(func_code) == block_seq_pkg::FC_COND_EXIT;
  endproperty
  a_exit: assert property (p_exit) else $error("exit flagged by wrong instruction");
  property p_hold; resp_hold_q |-> resp_valid_q && !resp_exec_q; endproperty
  a_hold: assert property (p_hold) else $error("held instruction also executed");
endmodule : block_seq_chk

// file: test/testbench.sv
// Purpose: Self-checking bench for the block program sequencer.
// Assumes: Inputs change at the falling edge; answers are read one cycle later.
// Notes: Wait units are shortened to a few cycles so timed holds stay brief.
`timescale 1ns/1ps
module testbench;
  localparam int TEN = 4;
  localparam int HUND = 8;
  localparam logic [9:0] BB = block_seq_pkg::FC_BLOCK_BEGIN;
  localparam logic [9:0] BE = block_seq_pkg::FC_BLOCK_END;
  localparam logic [9:0] BR = block_seq_pkg::FC_BRANCH;
  localparam logic [9:0] CW = block_seq_pkg::FC_COND_WAIT;
  localparam logic [9:0] CE = block_seq_pkg::FC_COND_EXIT;
  localparam logic [9:0] XI = 10'h040;
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, instr_valid = 1'b0;
  logic [9:0] func_code = 10'h000;
  logic invert = 1'b0, has_operand = 1'b0, operand_bit = 1'b0, exec_cond = 1'b0;
  logic [7:0] block_num = 8'h00;
  logic [15:0] set_value = 16'h0000;
  logic count_tick = 1'b0, parallel_mode = 1'b0, periph_priority_mode = 1'b0;
  logic resp_valid_q, resp_exec_q, resp_hold_q, resp_exit_q, periph_service_on_q, in_block_q;
  logic [7:0] cur_block_q;
  logic [255:0] block_paused_q;
  logic [3:0] r;
  int error_cnt = 0, checked = 0, cyc = 0;

  block_program_sequencer #(.TEN_CYC(TEN), .HUND_CYC(HUND)) block_program_sequencer_i (
    .ref_clk, .rst, .clk_en, .instr_valid, .func_code, .invert, .has_operand, .operand_bit,
    .exec_cond, .block_num, .set_value, .count_tick, .parallel_mode, .periph_priority_mode,
    .resp_valid_q, .resp_exec_q, .resp_hold_q, .resp_exit_q, .periph_service_on_q,
    .in_block_q, .cur_block_q, .block_paused_q);

  initial forever #12.5 ref_clk = ~ref_clk;

  task print_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // A hang in a wait loop must still reach the closing report.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end

  task check_resp(input logic [3:0] exp);
    checked++;
    if (r !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t resp %b expected %b", $time, r, exp);
    end
  endtask : check_resp

  task check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  // Holds the request through the taking edge, then reads valid, exec, hold, exit.
  task send(input logic [9:0] c, input logic i, h, o, e, input logic [7:0] b);
    instr_valid = 1'b1;
    func_code = c;
    invert = i;
    has_operand = h;
    operand_bit = o;
    exec_cond = e;
    block_num = b;
    @(negedge ref_clk);
    r = {resp_valid_q, resp_exec_q, resp_hold_q, resp_exit_q};
  endtask : send

  task sx(input logic [9:0] c, input logic i, h, o, e, input logic [7:0] b, input logic [3:0] x);
    send(c, i, h, o, e, b);
    check_resp(x);
  endtask : sx

  task idle;
    instr_valid = 1'b0;
    @(negedge ref_clk);
  endtask : idle

  task t_reset;
    check_bit(periph_service_on_q, 1'b1);
    check_bit(in_block_q, 1'b0);
    check_bit(cur_block_q == 8'h00, 1'b1);
    check_bit(block_paused_q == '0, 1'b1);
    $display("t_reset done");
  endtask : t_reset

  task t_exit;
    sx(BB, 0, 0, 0, 1, 8'h05, 4'b1100);
    check_bit(cur_block_q == 8'h05, 1'b1);
    sx(CE, 0, 1, 1, 0, 8'h00, 4'b1101);
    sx(XI, 0, 0, 0, 1, 8'h00, 4'b1000);
    sx(BE, 0, 0, 0, 1, 8'h00, 4'b1100);
    check_bit(in_block_q, 1'b0);
    sx(BB, 0, 0, 0, 1, 8'h06, 4'b1100);
    send(CE, 1, 1, 1, 1, 8'h00);
    check_bit(r[0], 1'b0);
    send(CE, 0, 0, 0, 0, 8'h00);
    check_bit(r[0], 1'b0);
    sx(CE, 1, 1, 0, 1, 8'h00, 4'b1101);
    sx(BE, 0, 0, 0, 1, 8'h00, 4'b1100);
    idle;
    $display("t_exit done");
  endtask : t_exit

  task t_branch;
    logic inv, b, run;
    sx(BB, 0, 0, 0, 1, 8'h01, 4'b1100);
    for (int i = 0; i < 4; i++) begin
      inv = i[1];
      b = i[0];
      run = ~(inv ^ b);
      sx(BR, inv, inv, b, b, 8'h00, 4'b1100);
      sx(XI, 0, 0, 0, 1, 8'h00, {1'b1, run, 2'b00});
      sx(block_seq_pkg::FC_BRANCH_ALT, 0, 0, 0, 1, 8'h00, 4'b1100);
      sx(XI, 0, 0, 0, 1, 8'h00, {1'b1, ~run, 2'b00});
      sx(block_seq_pkg::FC_BRANCH_CLOSE, 0, 0, 0, 1, 8'h00, 4'b1100);
      sx(XI, 0, 0, 0, 1, 8'h00, 4'b1100);
    end
    sx(BE, 0, 0, 0, 1, 8'h00, 4'b1100);
    idle;
    $display("t_branch done");
  endtask : t_branch

  task t_wait;
    sx(BB, 0, 0, 0, 1, 8'h02, 4'b1100);
    sx(CW, 0, 0, 0, 0, 8'h00, 4'b1010);
    sx(CW, 0, 0, 0, 0, 8'h00, 4'b1010);
    sx(CW, 0, 0, 0, 1, 8'h00, 4'b1100);
    sx(CW, 1, 1, 1, 0, 8'h00, 4'b1010);
    sx(CW, 1, 1, 0, 0, 8'h00, 4'b1100);
    sx(BE, 0, 0, 0, 1, 8'h00, 4'b1100);
    idle;
    $display("t_wait done");
  endtask : t_wait

  // Re-presents a held wait each cycle; counter waits see one event every fourth cycle.
  task run_wait(input logic [9:0] c, input logic [15:0] sv, input int nom);
    int n;
    logic cnt;
    n = 0;
    cnt = (c == block_seq_pkg::FC_COUNT_HOLD) || (c == block_seq_pkg::FC_COUNT_HOLD_EXT);
    set_value = sv;
    send(c, 0, 0, 0, 1, 8'h00);
    while (r[1] === 1'b1 && n < 100) begin
      n++;
      count_tick = cnt && (n % 4 == 0);
      send(c, 0, 0, 0, 1, 8'h00);
    end
    count_tick = 1'b0;
    check_bit(r[2], 1'b1);
    check_bit(n >= nom - 1 && n <= nom + 4, 1'b1);
  endtask : run_wait

  task t_timer;
    sx(BB, 0, 0, 0, 1, 8'h04, 4'b1100);
    run_wait(block_seq_pkg::FC_TEN_MS_DELAY, 16'h0002, 2 * TEN);
    run_wait(block_seq_pkg::FC_HUNDRED_MS_DELAY, 16'h0002, 2 * HUND);
    run_wait(block_seq_pkg::FC_HUNDRED_MS_DELAY_EXT, 16'h0001, HUND);
    run_wait(block_seq_pkg::FC_COUNT_HOLD, 16'h0003, 12);
    run_wait(block_seq_pkg::FC_COUNT_HOLD_EXT, 16'h0003, 12);
    sx(BE, 0, 0, 0, 1, 8'h00, 4'b1100);
    idle;
    $display("t_timer done");
  endtask : t_timer

  task t_pause;
    sx(BB, 0, 0, 0, 1, 8'h01, 4'b1100);
    sx(block_seq_pkg::FC_BLOCK_PAUSE, 0, 0, 0, 1, 8'h03, 4'b1100);
    check_bit(block_paused_q[3], 1'b1);
    sx(BE, 0, 0, 0, 1, 8'h00, 4'b1100);
    sx(BB, 0, 0, 0, 1, 8'h03, 4'b1010);
    check_bit(in_block_q, 1'b0);
    sx(BB, 0, 0, 0, 1, 8'h01, 4'b1100);
    sx(block_seq_pkg::FC_BLOCK_RESTART, 0, 0, 0, 1, 8'h03, 4'b1100);
    check_bit(block_paused_q[3], 1'b0);
    sx(BE, 0, 0, 0, 1, 8'h00, 4'b1100);
    sx(BB, 0, 0, 0, 1, 8'h03, 4'b1100);
    check_bit(cur_block_q == 8'h03, 1'b1);
    sx(BE, 0, 0, 0, 1, 8'h00, 4'b1100);
    idle;
    $display("t_pause done");
  endtask : t_pause

  task t_periph;
    send(block_seq_pkg::FC_PERIPH_SERVICE_DISABLE, 0, 0, 0, 1, 8'h00);
    check_bit(periph_service_on_q, 1'b1);
    periph_priority_mode = 1'b1;
    send(block_seq_pkg::FC_PERIPH_SERVICE_DISABLE, 0, 0, 0, 1, 8'h00);
    check_bit(periph_service_on_q, 1'b0);
    periph_priority_mode = 1'b0;
    send(block_seq_pkg::FC_PERIPH_SERVICE_ENABLE, 0, 0, 0, 1, 8'h00);
    check_bit(periph_service_on_q, 1'b0);
    parallel_mode = 1'b1;
    send(block_seq_pkg::FC_PERIPH_SERVICE_ENABLE, 0, 0, 0, 1, 8'h00);
    check_bit(periph_service_on_q, 1'b1);
    send(block_seq_pkg::FC_PERIPH_SERVICE_DISABLE, 0, 0, 0, 1, 8'h00);
    check_bit(periph_service_on_q, 1'b0);
    send(block_seq_pkg::FC_PERIPH_SERVICE_ENABLE, 0, 0, 0, 0, 8'h00);
    check_bit(periph_service_on_q, 1'b0);
    send(block_seq_pkg::FC_PERIPH_SERVICE_ENABLE, 0, 0, 0, 1, 8'h00);
    check_bit(periph_service_on_q, 1'b1);
    idle;
    $display("t_periph done");
  endtask : t_periph

  // A frozen cycle must neither take the instruction nor move any output; then a mid-run
  // reset must restore servicing and close the open block.
  task t_freeze;
    sx(BB, 0, 0, 0, 1, 8'h07, 4'b1100);
    clk_en = 1'b0;
    send(BE, 0, 0, 0, 1, 8'h00);
    check_resp(4'b1100);
    check_bit(in_block_q, 1'b1);
    clk_en = 1'b1;
    sx(BE, 0, 0, 0, 1, 8'h00, 4'b1100);
    check_bit(in_block_q, 1'b0);
    send(block_seq_pkg::FC_PERIPH_SERVICE_DISABLE, 0, 0, 0, 1, 8'h00);
    check_bit(periph_service_on_q, 1'b0);
    sx(BB, 0, 0, 0, 1, 8'h09, 4'b1100);
    instr_valid = 1'b0;
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    t_reset;
    $display("t_freeze done");
  endtask : t_freeze

  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    t_reset;
    t_exit;
    t_branch;
    t_wait;
    t_timer;
    t_pause;
    t_periph;
    t_freeze;
    print_verdict;
  end
endmodule : testbench

bind block_program_sequencer block_seq_chk #(.BLOCK_W(BLOCK_W)) block_seq_chk_i (
  .ref_clk, .rst, .clk_en, .instr_valid, .func_code, .exec_cond, .block_num, .parallel_mode,
  .periph_priority_mode, .resp_valid_q, .resp_exec_q, .resp_hold_q, .resp_exit_q,
  .periph_service_on_q, .in_block_q, .cur_block_q, .block_paused_q);
